// ### include/upmux_cfg.svh
// Purpose: Constants for the upper port pin multiplexer
// Assumes: Included by the package and the design modules
// Notes: Offsets are word indices on the plain register port
`ifndef UPMUX_CFG_SVH
`define UPMUX_CFG_SVH

`define UPM_AW 3
`define UPM_DW 16
`define UPM_NPIN 8

// Register offsets
`define UPM_OFS_PDATA 3'h0
`define UPM_OFS_PDIR 3'h1
`define UPM_OFS_UAC 3'h2
`define UPM_OFS_LEVEL 3'h3
`define UPM_OFS_FNSEL 3'h4
`define UPM_OFS_CONFL 3'h5

// Reset values
`define UPM_RST_PDATA 8'h00
`define UPM_RST_PDIR 8'h00
`define UPM_RST_UAC 8'h00
`define UPM_RST_RDATA 16'h0000
`define UPM_RST_PADOUT 8'h00
`define UPM_RST_PADOEN 8'hff
`define UPM_RST_PWIN 4'h0
`define UPM_IDLE_RX 1'b1
`define UPM_IDLE_SCK 1'b1

// Pin positions
`define UPM_PIN_ALT_TX 0
`define UPM_PIN_SCK 1
`define UPM_PIN_RX 2
`define UPM_PIN_MAIN_TX 3
`define UPM_PIN_PW0 4
`define UPM_PIN_PW1 5
`define UPM_PIN_PW2 6
`define UPM_PIN_PW3 7

// Pins that own a port bit and an address line
`define UPM_ADDR_PINS 8'hef
// Pins whose level feeds a peripheral input
`define UPM_INPUT_PINS 8'hf6

`endif

// ### include/upmux_pkg.sv
// Purpose: Types for the upper port pin multiplexer
// Assumes: upmux_cfg.svh gives the widths
// Notes: Carrier structs group peripheral and pad signals
`include "upmux_cfg.svh"

package upmux_pkg;

  typedef enum logic [1:0] {
    UPM_FN_NONE,
    UPM_FN_PORT,
    UPM_FN_ADDR,
    UPM_FN_PERIPH
  } upmux_fn_e;

  typedef struct packed {
    logic alt_tx_en;
    logic alt_tx_data;
    logic main_tx_en;
    logic main_tx_data;
    logic sck_out_en;
    logic sck_out;
    logic sck_ext_mode;
    logic rx_en;
    logic [3:0] pw_in_en;
    logic [3:0] pw_out_en;
    logic [3:0] pw_out;
  } upmux_periph_s;

  typedef struct packed {
    logic [`UPM_NPIN-1:0] out;
    logic [`UPM_NPIN-1:0] oe_n;
  } upmux_pad_s;

  typedef logic [`UPM_DW-1:0] upmux_word_t;

endpackage : upmux_pkg

// ### core/upmux_sync.sv
// Purpose: Two-stage synchroniser for the pad input levels
// Assumes: Reset is the already released copy
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
`include "upmux_cfg.svh"

module upmux_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_sync_n,
  // Levels
  input wire logic [`UPM_NPIN-1:0] async_in,
  output logic [`UPM_NPIN-1:0] sync_out
);
  import upmux_pkg::*;

  logic [`UPM_NPIN-1:0] meta_r;
  logic [`UPM_NPIN-1:0] sync_r;

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule : upmux_sync

// ### core/upmux_top.sv
// Purpose: Pin function selection for the eight upper port pins
// Assumes: Peripheral and bus signals come from the ref_clk domain
// Notes: Pad levels pass two flip-flops before any use
`timescale 1ns/1ns
`include "upmux_cfg.svh"

// Overview of operation
// - Bit 0 port when alt tx off, port-selected
// - Bit 0 drives address 16 in bus mode
// - Alt serial transmit owns bit 0 when on
// - Bit 1 port when clock out off, port-selected
// - Bit 1 drives address 17 in bus mode
// - Serial clock output owns bit 1 when on
// - Bit 1 input feeds external serial clock
// - Bits 2,5,6,7 port in single-chip or port
// - Bits 2,5,6,7 drive addresses 18,21,22,23
// - Bit 2 level feeds serial receive input
// - Bit 3 port when main tx off, port-selected
// - Bit 3 drives address 19 in bus mode
// - Main serial transmit owns bit 3 when on
// - Timer pin level feeds pulse channel 0
// - Pulse channel 0 output drives timer pin
// - Bits 5,6,7 feed pulse channels 1 to 3
// - Pulse channels 1 to 3 drive bits 5-7
module upmux_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [`UPM_AW-1:0] reg_addr,
  input wire logic [`UPM_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output upmux_pkg::upmux_word_t reg_rdata,
  // Chip mode and bus controller
  input wire logic single_chip,
  input wire logic [`UPM_NPIN-1:0] ext_addr_hi,
  // Peripherals
  input wire upmux_pkg::upmux_periph_s periph,
  output logic serial_rx_in,
  output logic serial_shift_clock_in,
  output logic [3:0] pulse_width_in,
  // Pads
  input wire logic [`UPM_NPIN-1:0] pad_in,
  output upmux_pkg::upmux_pad_s pad
);
  import upmux_pkg::*;

  // Pins that own a port bit and an address line
  localparam logic [`UPM_NPIN-1:0] ADDR_PIN_MASK = `UPM_ADDR_PINS;
  // Pins whose level feeds a peripheral input
  localparam logic [`UPM_NPIN-1:0] INPUT_PIN_MASK = `UPM_INPUT_PINS;

  // Reset release
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Pad level synchronisation
  logic [`UPM_NPIN-1:0] pin_lvl;

  upmux_sync u_sync (
    .ref_clk(ref_clk),
    .rst_sync_n(rst_sync_r),
    .async_in(pad_in),
    .sync_out(pin_lvl)
  );

  // Decides which function owns a pin
  function automatic upmux_fn_e pin_fn(
    input logic periph_en,
    input logic addr_pin,
    input logic chip_single,
    input logic uac_addr
  );
    upmux_fn_e fn;
    if (periph_en) begin
      fn = UPM_FN_PERIPH;
      // Pin 4 has no port bit or address line
    end else if (!addr_pin) begin
      fn = UPM_FN_NONE;
    end else if (chip_single || !uac_addr) begin
      fn = UPM_FN_PORT;
    end else begin
      fn = UPM_FN_ADDR;
    end
    return fn;
  endfunction : pin_fn

  // Register write decode
  function automatic logic wr_hit(
    input logic wr,
    input logic [`UPM_AW-1:0] addr,
    input logic [`UPM_AW-1:0] ofs
  );
    return wr && (addr == ofs);
  endfunction : wr_hit

  // Software registers
  logic [`UPM_NPIN-1:0] port_data_r;
  logic [`UPM_NPIN-1:0] port_data_nxt;
  logic [`UPM_NPIN-1:0] port_dir_r;
  logic [`UPM_NPIN-1:0] port_dir_nxt;
  logic [`UPM_NPIN-1:0] uac_r;
  logic [`UPM_NPIN-1:0] uac_nxt;
  upmux_word_t rdata_r;
  upmux_word_t rdata_nxt;

  // Function map and conflict view
  upmux_fn_e fn_sel [`UPM_NPIN];
  logic [2*`UPM_NPIN-1:0] fn_word;
  logic [`UPM_NPIN-1:0] in_use;
  logic [`UPM_NPIN-1:0] conflict;

  always_comb begin
    port_data_nxt = port_data_r;
    port_dir_nxt = port_dir_r;
    uac_nxt = uac_r;
    if (wr_hit(reg_wr, reg_addr, `UPM_OFS_PDATA)) begin
      port_data_nxt = reg_wdata[`UPM_NPIN-1:0] & `UPM_ADDR_PINS;
    end
    if (wr_hit(reg_wr, reg_addr, `UPM_OFS_PDIR)) begin
      port_dir_nxt = reg_wdata[`UPM_NPIN-1:0] & `UPM_ADDR_PINS;
    end
    if (wr_hit(reg_wr, reg_addr, `UPM_OFS_UAC)) begin
      uac_nxt = reg_wdata[`UPM_NPIN-1:0] & `UPM_ADDR_PINS;
    end
  end

  always_comb begin
    rdata_nxt = '0;
    if (reg_rd) begin
      case (reg_addr)
        `UPM_OFS_PDATA: begin
          rdata_nxt[`UPM_NPIN-1:0] = port_data_r;
        end
        `UPM_OFS_PDIR: begin
          rdata_nxt[`UPM_NPIN-1:0] = port_dir_r;
        end
        `UPM_OFS_UAC: begin
          rdata_nxt[`UPM_NPIN-1:0] = uac_r;
        end
        `UPM_OFS_LEVEL: begin
          rdata_nxt[`UPM_NPIN-1:0] = pin_lvl;
        end
        `UPM_OFS_FNSEL: begin
          rdata_nxt = fn_word;
        end
        `UPM_OFS_CONFL: begin
          rdata_nxt[`UPM_NPIN-1:0] = conflict;
        end
        default: begin
          rdata_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      port_data_r <= `UPM_RST_PDATA;
      port_dir_r <= `UPM_RST_PDIR;
      uac_r <= `UPM_RST_UAC;
      rdata_r <= `UPM_RST_RDATA;
    end else begin
      port_data_r <= port_data_nxt;
      port_dir_r <= port_dir_nxt;
      uac_r <= uac_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // Peripheral output claims per pin
  logic [`UPM_NPIN-1:0] per_en;
  logic [`UPM_NPIN-1:0] per_val;

  always_comb begin
    per_en = '0;
    per_val = '0;
    per_en[`UPM_PIN_ALT_TX] = periph.alt_tx_en;
    per_val[`UPM_PIN_ALT_TX] = periph.alt_tx_data;
    per_en[`UPM_PIN_SCK] = periph.sck_out_en;
    per_val[`UPM_PIN_SCK] = periph.sck_out;
    per_en[`UPM_PIN_MAIN_TX] = periph.main_tx_en;
    per_val[`UPM_PIN_MAIN_TX] = periph.main_tx_data;
    per_en[`UPM_PIN_PW0] = periph.pw_out_en[0];
    per_val[`UPM_PIN_PW0] = periph.pw_out[0];
    per_en[`UPM_PIN_PW3:`UPM_PIN_PW1] = periph.pw_out_en[3:1];
    per_val[`UPM_PIN_PW3:`UPM_PIN_PW1] = periph.pw_out[3:1];
  end

  // Pad drive selection, one owner per pin
  // Peripheral output first, then port or address
  upmux_pad_s pad_r;
  upmux_pad_s pad_nxt;

  always_comb begin
    pad_nxt.out = `UPM_RST_PADOUT;
    pad_nxt.oe_n = `UPM_RST_PADOEN;
    for (int i = 0; i < `UPM_NPIN; i++) begin
      fn_sel[i] = pin_fn(per_en[i], ADDR_PIN_MASK[i],
                         single_chip, uac_r[i]);
      fn_word[2*i +: 2] = fn_sel[i];
      case (fn_sel[i])
        UPM_FN_PERIPH: begin
          pad_nxt.out[i] = per_val[i];
          pad_nxt.oe_n[i] = 1'b0;
        end
        UPM_FN_ADDR: begin
          pad_nxt.out[i] = ext_addr_hi[i];
          pad_nxt.oe_n[i] = 1'b0;
        end
        UPM_FN_PORT: begin
          pad_nxt.out[i] = port_data_r[i];
          pad_nxt.oe_n[i] = ~port_dir_r[i];
        end
        default: begin
          pad_nxt.out[i] = 1'b0;
          pad_nxt.oe_n[i] = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      pad_r.out <= `UPM_RST_PADOUT;
      pad_r.oe_n <= `UPM_RST_PADOEN;
    end else begin
      pad_r <= pad_nxt;
    end
  end

  assign pad = pad_r;

  // Peripheral inputs taken from pin levels
  logic rx_r;
  logic rx_nxt;
  logic sck_in_r;
  logic sck_in_nxt;
  logic [3:0] pw_in_r;
  logic [3:0] pw_in_nxt;
  logic sck_ext_sel;

  always_comb begin
    sck_ext_sel = periph.sck_ext_mode && !periph.sck_out_en &&
                  !port_dir_r[`UPM_PIN_SCK];
    sck_in_nxt = `UPM_IDLE_SCK;
    if (sck_ext_sel) begin
      sck_in_nxt = pin_lvl[`UPM_PIN_SCK];
    end
    rx_nxt = `UPM_IDLE_RX;
    if (periph.rx_en) begin
      rx_nxt = pin_lvl[`UPM_PIN_RX];
    end
    pw_in_nxt = `UPM_RST_PWIN;
    if (periph.pw_in_en[0]) begin
      pw_in_nxt[0] = pin_lvl[`UPM_PIN_PW0];
    end
    for (int c = 1; c < 4; c++) begin
      if (periph.pw_in_en[c]) begin
        pw_in_nxt[c] = pin_lvl[`UPM_PIN_PW0 + c];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rx_r <= `UPM_IDLE_RX;
      sck_in_r <= `UPM_IDLE_SCK;
      pw_in_r <= `UPM_RST_PWIN;
    end else begin
      rx_r <= rx_nxt;
      sck_in_r <= sck_in_nxt;
      pw_in_r <= pw_in_nxt;
    end
  end

  assign serial_rx_in = rx_r;
  assign serial_shift_clock_in = sck_in_r;
  assign pulse_width_in = pw_in_r;

  // Input pins also being driven; software should keep this clear
  always_comb begin
    in_use = '0;
    in_use[`UPM_PIN_SCK] = sck_ext_sel;
    in_use[`UPM_PIN_RX] = periph.rx_en;
    in_use[`UPM_PIN_PW3:`UPM_PIN_PW0] = periph.pw_in_en;
    conflict = in_use & ~pad_r.oe_n & INPUT_PIN_MASK;
  end

endmodule : upmux_top

// ### test/upmux_board.sv
// Purpose: Board model around the eight upper port pads
// Assumes: Board drives only pins the block leaves undriven
// Notes: A floating pin flips level every cycle
`timescale 1ns/1ns
module upmux_board (
  // Clock
  input wire logic ref_clk,
  // Pads
  input wire upmux_pkg::upmux_pad_s pad,
  input wire logic [7:0] drv,
  input wire logic [7:0] val,
  output logic [7:0] pad_in,
  output logic clash
);
  import upmux_pkg::*;
  logic [7:0] float_r = 8'h00;
  always @(posedge ref_clk) float_r <= ~float_r;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad.oe_n[i]) pad_in[i] = pad.out[i];
      else if (drv[i]) pad_in[i] = val[i];
      else pad_in[i] = float_r[i];
    end
  end
  // Board stays off driven pins
  assign clash = |(drv & ~pad.oe_n);
endmodule : upmux_board

// ### test/upmux_chk.sv
// Purpose: Port-level checks of the upper port pin mux
// Assumes: Bound into upmux_top
// Notes: Checks wait until internal reset has settled
`timescale 1ns/1ns
module upmux_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Peripherals
  input wire upmux_pkg::upmux_periph_s periph,
  input wire logic serial_rx_in,
  input wire logic serial_shift_clock_in,
  input wire logic [3:0] pulse_width_in,
  // Pads
  input wire logic [7:0] pad_in,
  input wire upmux_pkg::upmux_pad_s pad
);
  import upmux_pkg::*;
  logic [5:0] up_r;
  logic [5:0] up_nxt;
  logic ok;
  assign up_nxt = {up_r[4:0], 1'b1};
  assign ok = up_r[5];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) up_r <= 6'h00;
    else up_r <= up_nxt;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_ALT_TX: assert property (ok && periph.alt_tx_en |=>
    !pad.oe_n[0] && pad.out[0] == $past(periph.alt_tx_data))
    else $error("pin 0 not alt tx");
  AST_SCK_OUT: assert property (ok && periph.sck_out_en |=>
    !pad.oe_n[1] && pad.out[1] == $past(periph.sck_out))
    else $error("pin 1 not clock");
  AST_MAIN_TX: assert property (ok && periph.main_tx_en |=>
    !pad.oe_n[3] && pad.out[3] == $past(periph.main_tx_data))
    else $error("pin 3 not main tx");
  AST_PW0_OUT: assert property (ok && periph.pw_out_en[0] |=>
    !pad.oe_n[4] && pad.out[4] == $past(periph.pw_out[0]))
    else $error("pin 4 not timer out");
  AST_PW3_OUT: assert property (ok && periph.pw_out_en[3] |=>
    !pad.oe_n[7] && pad.out[7] == $past(periph.pw_out[3]))
    else $error("pin 7 not timer out");
  AST_PIN4_FLOAT: assert property (ok && !periph.pw_out_en[0] [*2]
    |-> pad.oe_n[4]) else $error("pin 4 driven");
  AST_RX_IN: assert property (ok && periph.rx_en |=>
    serial_rx_in == $past(pad_in[2], 3)) else $error("rx level");
  AST_PW0_IN: assert property (ok && periph.pw_in_en[0] |=>
    pulse_width_in[0] == $past(pad_in[4], 3)) else $error("pw0 level");
  AST_PW1_IN: assert property (ok && periph.pw_in_en[1] |=>
    pulse_width_in[1] == $past(pad_in[5], 3)) else $error("pw1 level");
  AST_SCK_IDLE: assert property (ok && !periph.sck_ext_mode |=>
    serial_shift_clock_in) else $error("clock in not idle");
  cover property (ok && periph.alt_tx_en && periph.pw_out_en[3]);
  cover property (ok && periph.rx_en && !pad_in[2]);
  cover property (ok && periph.sck_ext_mode && !pad_in[1]);
endmodule : upmux_chk
bind upmux_top upmux_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .periph(periph), .serial_rx_in(serial_rx_in),
  .serial_shift_clock_in(serial_shift_clock_in),
  .pulse_width_in(pulse_width_in), .pad_in(pad_in), .pad(pad));

// ### test/upper_port_pin_mux_test.sv
// Purpose: Self-checking bench for the upper port pin mux
// Assumes: Board model drives only undriven pads
// Notes: Pads settle one edge after a mode, address or peripheral change
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  n_errors++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module upper_port_pin_mux_test;
  import upmux_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic single_chip = 1'b1;
  logic [7:0] ext_addr_hi = 8'h00;
  upmux_periph_s periph = '0;
  logic [7:0] drv = 8'h00;
  logic [7:0] val = 8'h00;
  upmux_word_t reg_rdata;
  logic rx;
  logic sck;
  logic clash;
  logic clash_seen = 1'b0;
  logic [3:0] pw;
  logic [7:0] pad_in;
  upmux_pad_s pad;
  int n_errors = 0;
  int comparisons = 0;
  always #25 ref_clk = ~ref_clk;
  // Sticky record of any board drive onto a driven pad
  always @(posedge ref_clk) if (clash) clash_seen <= 1'b1;
  upmux_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .single_chip(single_chip),
    .ext_addr_hi(ext_addr_hi), .periph(periph), .serial_rx_in(rx),
    .serial_shift_clock_in(sck), .pulse_width_in(pw),
    .pad_in(pad_in), .pad(pad));
  upmux_board u_board (.ref_clk(ref_clk), .pad(pad), .drv(drv),
    .val(val), .pad_in(pad_in), .clash(clash));
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= {8'h00, d};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask : rd
  // Mode, upper address and peripheral controls
  task drive(input logic sc, input logic [7:0] ea, input upmux_periph_s p);
    @(posedge ref_clk);
    single_chip <= sc;
    ext_addr_hi <= ea;
    periph <= p;
  endtask : drive
  task pads(input logic [7:0] o, input logic [7:0] m, input logic [7:0] oe);
    tick(2);
    `CHK(pad.out & m, o)
    `CHK(pad.oe_n, oe)
  endtask : pads
  task t_reset;
    tick(5);
    `CHK(pad.oe_n, 8'hff)
    @(posedge ref_clk);
    rst_n <= 1'b1;
    tick(3);
    rd(3'h0, 16'h0000);
    rd(3'h1, 16'h0000);
    rd(3'h2, 16'h0000);
    rd(3'h6, 16'h0000);
    $display("t_reset done");
  endtask : t_reset
  task t_port;
    drive(1'b1, 8'hff, '0);
    wr(3'h1, 8'hff);
    wr(3'h0, 8'ha5);
    wr(3'h2, 8'hff);
    pads(8'ha5, 8'hef, 8'h10);
    rd(3'h2, 16'h00ef);
    rd(3'h4, 16'h5455);
    wr(3'h1, 8'h00);
    pads(8'h00, 8'h00, 8'hff);
    $display("t_port done");
  endtask : t_port
  task t_addr;
    drive(1'b0, 8'h6b, '0);
    wr(3'h1, 8'hff);
    wr(3'h0, 8'h00);
    wr(3'h2, 8'hef);
    pads(8'h6b, 8'hef, 8'h10);
    rd(3'h4, 16'ha8aa);
    wr(3'h2, 8'h00);
    pads(8'h00, 8'hef, 8'h10);
    $display("t_addr done");
  endtask : t_addr
  // Struct bits: tx, clock, mode, rx, pw in, pw out en, pw out
  task t_periph;
    wr(3'h2, 8'hef);
    drive(1'b0, 8'h00, 20'hf80fa);
    pads(8'ha9, 8'hff, 8'h00);
    drive(1'b0, 8'h00, 20'had0f5);
    pads(8'h52, 8'hff, 8'h00);
    rd(3'h5, 16'h0004);
    $display("t_periph done");
  endtask : t_periph
  task t_inputs;
    wr(3'h1, 8'h00);
    drive(1'b1, 8'h00, 20'h03f00);
    // Board waits until the pads are released
    @(posedge ref_clk);
    drv <= 8'hff;
    val <= 8'h5a;
    tick(4);
    `CHK({rx, sck, pw}, 6'h15)
    rd(3'h3, 16'h005a);
    @(posedge ref_clk);
    val <= 8'ha5;
    tick(4);
    `CHK({rx, sck, pw}, 6'h2a)
    `CHK(clash | clash_seen, 1'b0)
    drive(1'b1, 8'h00, '0);
    tick(4);
    `CHK({rx, sck, pw}, 6'h30)
    $display("t_inputs done");
  endtask : t_inputs
  task final_report;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  initial begin
    #200000;
    n_errors++;
    final_report;
  end
  initial begin
    t_reset;
    t_port;
    t_addr;
    t_periph;
    t_inputs;
    final_report;
  end
endmodule : upper_port_pin_mux_test
